// [hdl/dmrbo_core.sv]
/*
 * dmrbo_core: captures the first two mode registers from mode-register-set
 * commands, decodes them and sequences beat column order for each burst.
 * Assumes command pins are synchronous to core_clk (sampled by this clock).
 */
// Overview of operation
// - burst type bit picks sequential or interleaved
// - length field: fixed chop, eight, or per-command
// - sequential eight reads wrap within nibble groups
// - interleaved eight reads: column equals start xor n
// - chopped reads drive first four, float rest
// - chopped writes: column bit two picks half
// - eight-beat writes ascend zero to seven
// - fixed chop starts write timing two clocks early
// - loop reset bit clears itself after use
// - recovery field sets auto precharge delay
// - power-down exit speed follows bit twelve
// - second register written with bank zero high
// - loop off in self refresh, back after
// - drive impedance from bits one and five
// - additive delay added to read/write delays
// - disconnect bit floats all data outputs
// - first register written with all banks low
// - read column delay from bits two, four-six
`timescale 1ns/1ps
`default_nettype none
module dmrbo_core (
  input  wire logic                     core_clk,          // command clock
  input  wire logic                     arst_n,            // async reset, active low
  input  wire logic                     cs_n,              // chip select, low active
  input  wire logic                     ras_n,             // row strobe, low active
  input  wire logic                     cas_n,             // column strobe, low active
  input  wire logic                     we_n,              // write enable, low active
  input  wire logic [2:0]               bank_addr,         // bank address
  input  wire logic [15:0]              addr,              // address lines
  input  wire logic                     self_refresh,      // device in self refresh
  output logic                          beat_valid,        // a beat slot is active
  output logic [2:0]                    beat_col,          // column of current beat
  output logic                          beat_drive,        // drivers on this slot
  output logic                          beat_is_read,      // current burst is a read
  output logic                          dll_reset_pulse,   // loop reset strobe
  output logic                          loop_running,      // loop enabled and running
  output logic                          outputs_off,       // data and strobe disconnected
  output logic [3:0]                    read_delay_total,  // additive plus read column
  output logic [3:0]                    write_delay_total, // additive plus write column
  input  wire logic [3:0]               write_column_delay,// from third register
  output logic [4:0]                    auto_precharge_wr, // recovery clocks
  output logic                          fast_exit,         // power-down exit is fast
  output logic [1:0]                    drive_strength,    // output impedance select
  output logic [2:0]                    rtt_nom,           // nominal termination code
  output logic                          write_level,       // write leveling mode
  output logic [1:0]                    write_pull_in,     // clocks write timing starts early
  output dmrbo_pkg::dmrbo_cfg_t         cfg                // decoded configuration
);

  dmrbo_pkg::dmrbo_state_t st;
  dmrbo_pkg::dmrbo_state_t next_st;
  dmrbo_pkg::dmrbo_cfg_t   dec;

  // column of beat n for a start column
  function automatic logic [2:0] order_col(input logic [2:0] start, input logic [2:0] n,
                                          input logic il);
    logic [2:0] r;
    r = 3'h0;
    if (il) begin
      r = start ^ n;
    end else begin
      r[2]   = start[2] ^ n[2];
      r[1:0] = 2'(start[1:0] + n[1:0]);
    end
    return r;
  endfunction : order_col

  // recovery code to clocks; code zero reads as the largest
  function automatic logic [4:0] wr_clocks(input logic [2:0] code);
    logic [4:0] w;
    w = 5'h10;
    unique case (code)
      3'h0: w = 5'h10;
      3'h1: w = 5'h05;
      3'h2: w = 5'h06;
      3'h3: w = 5'h07;
      3'h4: w = 5'h08;
      3'h5: w = 5'h0a;
      3'h6: w = 5'h0c;
      3'h7: w = 5'h0e;
    endcase
    return w;
  endfunction : wr_clocks

  logic mrs_cmd;
  logic rw_cmd;
  logic is_read;
  logic cmd_chop;

  always_comb begin
    dec.burst_chop_four  = (st.mode_reg_zero[1:0] == dmrbo_pkg::BL_FIXED_CHOP);
    dec.interleaved      = st.mode_reg_zero[dmrbo_pkg::MR0_BTYPE];
    dec.read_column_delay = {st.mode_reg_zero[dmrbo_pkg::MR0_CL_LOW],
                             st.mode_reg_zero[dmrbo_pkg::MR0_CL_HI_LSB +: 3]};
    dec.wr_code          = st.mode_reg_zero[dmrbo_pkg::MR0_WR_LSB +: 3];
    dec.fast_exit        = st.mode_reg_zero[dmrbo_pkg::MR0_PD_FAST];
    dec.loop_enabled     = ~st.mode_reg_one[dmrbo_pkg::MR1_DLL_DIS];
    dec.drive_strength   = {st.mode_reg_one[dmrbo_pkg::MR1_DRV_HIGH],
                            st.mode_reg_one[dmrbo_pkg::MR1_DRV_LOW]};
    dec.rtt_nom          = {st.mode_reg_one[dmrbo_pkg::MR1_RTT_C],
                            st.mode_reg_one[dmrbo_pkg::MR1_RTT_B],
                            st.mode_reg_one[dmrbo_pkg::MR1_RTT_A]};
    dec.additive_sel     = st.mode_reg_one[dmrbo_pkg::MR1_AL_LSB +: 2];
    dec.write_level      = st.mode_reg_one[dmrbo_pkg::MR1_WLEV];
    dec.output_off       = st.mode_reg_one[dmrbo_pkg::MR1_QOFF];
  end

  logic [3:0] additive;
  always_comb begin
    // additive delay is zero, read delay less one, or less two
    unique case (dec.additive_sel)
      2'h1:    additive = 4'(dec.read_column_delay - 4'h1);
      2'h2:    additive = 4'(dec.read_column_delay - 4'h2);
      default: additive = 4'h0;
    endcase
  end

  always_comb begin
    mrs_cmd  = ~cs_n & ~ras_n & ~cas_n & ~we_n;
    rw_cmd   = ~cs_n & ras_n & ~cas_n;
    is_read  = we_n;
    unique case (st.mode_reg_zero[1:0])
      dmrbo_pkg::BL_FIXED_CHOP: cmd_chop = 1'b1;
      dmrbo_pkg::BL_ON_THE_FLY: cmd_chop = ~addr[dmrbo_pkg::CHOP_PIN];
      default:                  cmd_chop = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.dll_reset_pulse = 1'b0;
    next_st.in_self_refresh = self_refresh;
    // loop reset bit acts once then self-clears; a new write in the same
    // cycle comes after, so a fresh reset request is never lost
    if (st.mode_reg_zero[dmrbo_pkg::MR0_DLL_RST]) begin
      next_st.mode_reg_zero[dmrbo_pkg::MR0_DLL_RST] = 1'b0;
      next_st.dll_reset_pulse = 1'b1;
    end
    if (mrs_cmd && bank_addr == 3'h0) begin
      next_st.mode_reg_zero = addr;
    end
    if (mrs_cmd && bank_addr == 3'h1) begin
      next_st.mode_reg_one = addr;
    end
    // burst beat sequencing
    if (st.in_burst) begin
      next_st.beat = 3'(st.beat + 3'h1);
      if (st.beat == 3'h7) begin
        next_st.in_burst   = 1'b0;
        next_st.beat_valid = 1'b0;
        next_st.beat_drive = 1'b0;
      end
    end
    if (st.in_burst && st.beat != 3'h7) begin
      next_st.beat_col   = st.burst_is_read ?
                           order_col(st.start_col, 3'(st.beat + 3'h1), dec.interleaved) :
                           {st.start_col[2], 2'(st.beat[1:0] + 2'h1)} ^
                           {st.start_col[2] ? 1'b0 : (st.beat[2] | &st.beat[1:0]), 2'h0};
      next_st.beat_drive = st.burst_is_read & ~dec.output_off &
                           ~(st.burst_chop & (st.beat >= 3'h3));
    end
    if (rw_cmd && !st.in_burst) begin
      next_st.in_burst      = 1'b1;
      next_st.burst_is_read = is_read;
      next_st.burst_chop    = cmd_chop;
      next_st.beat          = 3'h0;
      next_st.beat_valid    = 1'b1;
      // writes ignore low column bits; chop keeps bit two only
      next_st.start_col     = is_read ? addr[2:0] :
                              (cmd_chop ? {addr[2], 2'h0} : 3'h0);
      next_st.beat_col      = is_read ? addr[2:0] :
                              (cmd_chop ? {addr[2], 2'h0} : 3'h0);
      next_st.beat_drive    = is_read & ~dec.output_off;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.mode_reg_zero <= dmrbo_pkg::MR_RESET;
      st.mode_reg_one  <= dmrbo_pkg::MR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // write beats: ascending within the chosen half or full eight
  assign beat_valid        = st.beat_valid;
  assign beat_col          = st.beat_col;
  assign beat_drive        = st.beat_drive;
  assign beat_is_read      = st.burst_is_read;
  assign dll_reset_pulse   = st.dll_reset_pulse;
  assign loop_running      = dec.loop_enabled & ~st.in_self_refresh;
  assign outputs_off       = dec.output_off;
  assign read_delay_total  = 4'(additive + dec.read_column_delay);
  assign write_delay_total = 4'(additive + write_column_delay);
  assign auto_precharge_wr = wr_clocks(dec.wr_code);
  assign fast_exit         = dec.fast_exit;
  assign drive_strength    = dec.drive_strength;
  assign rtt_nom           = dec.rtt_nom;
  assign write_level       = dec.write_level;
  // only fixed chop pulls in; per-command chop keeps eight-beat timing
  assign write_pull_in     = dec.burst_chop_four ? 2'(dmrbo_pkg::CHOP_PULL_IN) : 2'h0;
  assign cfg               = dec;

endmodule : dmrbo_core
`default_nettype wire

// [hdl/dmrbo_pkg.sv]
/*
 * dmrbo_pkg: constants and carrier types for the mode register decode block.
 * Assumes a single 40 MHz core clock and commands already decoded to pin levels.
 */
package dmrbo_pkg;

  // burst length field codes
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY  = 2'h1;
  localparam logic [1:0] BL_FIXED_CHOP  = 2'h2;

  // field positions, first mode register
  localparam int MR0_BL_LSB    = 0;
  localparam int MR0_CL_LOW    = 2;
  localparam int MR0_BTYPE     = 3;
  localparam int MR0_CL_HI_LSB = 4;
  localparam int MR0_DLL_RST   = 8;
  localparam int MR0_WR_LSB    = 9;
  localparam int MR0_PD_FAST   = 12;

  // field positions, second mode register
  localparam int MR1_DLL_DIS   = 0;
  localparam int MR1_DRV_LOW   = 1;
  localparam int MR1_RTT_A     = 2;
  localparam int MR1_AL_LSB    = 3;
  localparam int MR1_DRV_HIGH  = 5;
  localparam int MR1_RTT_B     = 6;
  localparam int MR1_WLEV      = 7;
  localparam int MR1_RTT_C     = 9;
  localparam int MR1_QOFF      = 12;

  localparam int ADDR_W        = 16;
  localparam int CHOP_PIN      = 12;
  localparam int CHOP_PULL_IN  = 2;    // clocks earlier for fixed chop
  localparam int DLL_RST_CYC   = 1;    // cycles the loop reset pulse stands

  localparam logic [15:0] MR_RESET = 16'h0000;

  typedef struct packed {
    logic [15:0] mode_reg_zero;
    logic [15:0] mode_reg_one;
    logic        in_self_refresh;
    logic        in_burst;
    logic        burst_is_read;
    logic        burst_chop;
    logic [2:0]  start_col;
    logic [2:0]  beat;
    logic [2:0]  beat_col;
    logic        beat_valid;
    logic        beat_drive;
    logic        dll_reset_pulse;
  } dmrbo_state_t;

  typedef struct packed {
    logic        burst_chop_four;
    logic        interleaved;
    logic [3:0]  read_column_delay;
    logic [2:0]  wr_code;
    logic        fast_exit;
    logic        loop_enabled;
    logic [1:0]  drive_strength;
    logic [2:0]  rtt_nom;
    logic [1:0]  additive_sel;
    logic        write_level;
    logic        output_off;
  } dmrbo_cfg_t;

endpackage : dmrbo_pkg

// [verification/dmrbo_core_chk.sv]
/* dmrbo_core_chk: timing and decode assertions on the core ports.
   assumes it is bound onto dmrbo_core; a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dmrbo_core_chk (
  input wire logic                  core_clk,         // clock
  input wire logic                  arst_n,           // reset
  input wire logic                  cs_n,             // select
  input wire logic                  ras_n,            // row strobe
  input wire logic                  cas_n,            // col strobe
  input wire logic                  we_n,             // write enable
  input wire logic [2:0]            bank_addr,        // bank
  input wire logic [15:0]           addr,             // address
  input wire logic                  beat_valid,       // slot active
  input wire logic [2:0]            beat_col,         // beat column
  input wire logic                  beat_drive,       // drivers on
  input wire logic                  beat_is_read,     // read burst
  input wire logic                  dll_reset_pulse,  // loop reset
  input wire logic                  outputs_off,      // disconnect
  input wire logic [3:0]            read_delay_total, // read delay
  input wire logic                  fast_exit,        // exit speed
  input wire logic [1:0]            drive_strength,   // impedance
  input wire logic [1:0]            write_pull_in,    // write pull-in
  input wire dmrbo_pkg::dmrbo_cfg_t cfg               // decode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire        mrs = !cs_n && !ras_n && !cas_n && !we_n;
  wire  [3:0] al = (cfg.additive_sel == 2'h1) ? cfg.read_column_delay - 4'h1 :
                   (cfg.additive_sel == 2'h2) ? cfg.read_column_delay - 4'h2 : 4'h0;
  logic [2:0] cnt;
  logic [2:0] first;
  // beat index and first column of the running burst
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt   <= 3'h0;
      first <= 3'h0;
    end else begin
      cnt   <= beat_valid ? cnt + 3'h1 : 3'h0;
      first <= (beat_valid && cnt == 3'h0) ? beat_col : first;
    end
  end
  property p_dll; dll_reset_pulse |-> $past(mrs && bank_addr == 3'h0 && addr[8], 2)
    ##1 !dll_reset_pulse; endproperty
  a_dll: assert property (p_dll) else $error("loop reset pulse wrong");
  property p_len; $rose(beat_valid) |-> beat_valid [*8]; endproperty
  a_len: assert property (p_len) else $error("burst slots not eight");
  property p_seq; beat_drive && !cfg.interleaved && cnt != 3'h0 |->
    beat_col == {first[2] ^ cnt[2], first[1:0] + cnt[1:0]}; endproperty
  a_seq: assert property (p_seq) else $error("sequential order wrong");
  property p_ilv; beat_drive && cfg.interleaved |-> cnt == 3'h0 || beat_col == (first ^ cnt);
  endproperty
  a_ilv: assert property (p_ilv) else $error("interleaved order wrong");
  property p_wr; beat_valid && !beat_is_read && !cnt[2] |-> beat_col[1:0] == cnt[1:0]; endproperty
  a_wr: assert property (p_wr) else $error("write order wrong");
  property p_chop; beat_valid && cnt[2] && cfg.burst_chop_four |-> !beat_drive; endproperty
  a_chop: assert property (p_chop) else $error("chop tail driven");
  property p_off; beat_valid && (outputs_off || !beat_is_read) |-> !beat_drive; endproperty
  a_off: assert property (p_off) else $error("drivers on while off");
  property p_pull; write_pull_in == (cfg.burst_chop_four ? 2'h2 : 2'h0); endproperty
  a_pull: assert property (p_pull) else $error("write pull-in wrong");
  property p_mr0; mrs && bank_addr == 3'h0 |=> fast_exit == $past(addr[12]); endproperty
  a_mr0: assert property (p_mr0) else $error("exit speed not loaded");
  property p_mr1; mrs && bank_addr == 3'h1 |=> outputs_off == $past(addr[12])
    && drive_strength == {$past(addr[5]), $past(addr[1])}; endproperty
  a_mr1: assert property (p_mr1) else $error("second register not loaded");
  property p_rl; read_delay_total == cfg.read_column_delay + al; endproperty
  a_rl: assert property (p_rl) else $error("read delay sum wrong");
endmodule : dmrbo_core_chk
bind dmrbo_core dmrbo_core_chk u_dmrbo_core_chk (.*);
`default_nettype wire

// [verification/dmrbo_ctrl_model.sv]
/* dmrbo_ctrl_model: controller side of the command bus, called by the bench.
   assumes pins may change only at falling edges of core_clk. */
`timescale 1ns/1ps
`default_nettype none
module dmrbo_ctrl_model #(
  parameter int LOCK_WAIT = 64 // idle clocks after a loop reset
) (
  input  wire logic        core_clk,  // command clock
  output var  logic        cs_n,      // select
  output var  logic        ras_n,     // row strobe
  output var  logic        cas_n,     // column strobe
  output var  logic        we_n,      // write enable
  output var  logic [2:0]  bank_addr, // bank
  output var  logic [15:0] addr       // address
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank_addr = 3'h0;
    addr = 16'h0;
  end
  // deselected lines flip so nothing leans on a stale value
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
    @(negedge core_clk);
    {cs_n, ras_n, cas_n, we_n} = c;
    bank_addr = b;
    addr = a;
    @(negedge core_clk);
    {cs_n, ras_n, cas_n, we_n} = {1'b1, ~c[2:0]};
    bank_addr = ~b;
    addr = ~a;
  endtask : issue
  task automatic mrs(input logic [2:0] b, input logic [15:0] a);
    issue(4'h0, b, a);
    if (b == 3'h0 && a[8]) repeat (LOCK_WAIT) @(negedge core_clk);
  endtask : mrs
  task automatic rw(input logic rd, input logic [15:0] a);
    issue({3'b010, rd}, 3'h0, a);
  endtask : rw
endmodule : dmrbo_ctrl_model
`default_nettype wire

// [verification/tb_dmrbo_core.sv]
/* tb_dmrbo_core: random bursts in every length code, loop reset, decode.
   assumes the controller model owns the command pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_dmrbo_core;
  logic        core_clk, arst_n, self_refresh, cs_n, ras_n, cas_n, we_n;
  logic        beat_valid, beat_drive, dll_reset_pulse, loop_running, outputs_off;
  logic [2:0]  bank_addr, beat_col;
  logic [3:0]  write_column_delay;
  logic [15:0] addr;
  logic [1:0]  drive_strength;
  logic [3:0]  write_delay_total;
  logic [4:0]  auto_precharge_wr;
  logic [2:0]  rtt_nom;
  logic        write_level;
  logic [31:0] seed = 32'hbbcc7015;
  int          bad_count = 0, tests_run = 0, cyc = 0, pulses = 0;
  dmrbo_core u_dmrbo_core (.*, .beat_is_read(), .read_delay_total(),
    .fast_exit(), .write_pull_in(), .cfg());
  dmrbo_ctrl_model u_dmrbo_ctrl_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [2:0] exp_col(logic rd, logic ilv, logic ch, logic [2:0] s, n);
    if (!rd) return ch ? {s[2], n[1:0]} : n;
    return ilv ? s ^ n : {s[2] ^ n[2], s[1:0] + n[1:0]};
  endfunction : exp_col
  // recovery clocks per code: 16, then 5..8, then 10, 12, 14
  function automatic logic [4:0] exp_wr(input logic [2:0] c);
    return (c == 3'h0) ? 5'h10 : (c < 3'h5) ? 5'(c) + 5'h04 : 5'(c) * 5'h02;
  endfunction : exp_wr
  // additive delay for the read column delay of 5 the bench programs
  function automatic logic [3:0] exp_al(input logic [1:0] s);
    return (s == 2'h1) ? 4'h4 : (s == 2'h2) ? 4'h3 : 4'h0;
  endfunction : exp_al
  task automatic chk_w(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge core_clk) begin
    cyc++;
    pulses <= pulses + int'(dll_reset_pulse === 1'b1);
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    logic [31:0] r;
    logic [1:0]  bl;
    logic        ch, rd;
    int          n;
    arst_n = 1'b0;
    self_refresh = 1'b0;
    write_column_delay = 4'h5;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    u_dmrbo_ctrl_model.mrs(3'h1, 16'h0000); // loop on before its reset
    u_dmrbo_ctrl_model.mrs(3'h0, 16'h0100);
    chk(3'(pulses), 3'h1);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      bl = 2'(i % 3);
      rd = r[4] | (i < 6);
      ch = bl == dmrbo_pkg::BL_FIXED_CHOP || (bl == dmrbo_pkg::BL_ON_THE_FLY && !r[8]);
      self_refresh = r[10];
      write_column_delay = r[14:11];
      // loop stays on; leveling and termination code bit zero from separate random bits
      u_dmrbo_ctrl_model.mrs(3'h1, {3'h0, i[2:0] == 3'h7, 4'h0, r[17], 1'b0, r[5],
                                    r[16:15], r[18], r[6], 1'b0});
      chk(3'(loop_running), 3'(!r[10]));
      self_refresh = 1'b0;
      u_dmrbo_ctrl_model.mrs(3'h0, {3'h0, r[9], r[2:0], 2'h0, 3'h5, r[3], 1'b0, bl});
      chk(3'(drive_strength), 3'({r[5], r[6]}));
      chk_w(auto_precharge_wr, exp_wr(r[2:0]));
      chk_w(5'(write_delay_total), 5'(4'(exp_al(r[16:15]) + write_column_delay)));
      chk(rtt_nom, {2'h0, r[18]});
      chk(3'(write_level), 3'(r[17]));
      u_dmrbo_ctrl_model.rw(rd, {3'h0, r[8], 9'h0, r[7:5]});
      n = 0;
      while (beat_valid !== 1'b1 && n < 4) begin
        @(negedge core_clk);
        n++;
      end
      for (int k = 0; k < 8; k++) begin
        if (!(ch && k > 3)) chk(beat_col, exp_col(rd, r[3], ch, r[7:5], 3'(k)));
        chk(3'(beat_drive), 3'(rd && !(ch && k > 3) && i[2:0] != 3'h7));
        chk(3'(beat_valid), 3'h1);
        @(negedge core_clk);
      end
      chk(3'(beat_valid), 3'h0);
      $display("burst test %0d done", i);
    end
    conclude();
  end
endmodule : tb_dmrbo_core
`default_nettype wire
